// >>> src/ccsr_bank_ctl.v
`timescale 1ns/1ps
`default_nettype none
`include "ccsr_defs.vh"
// ****************************************************
// context bank stall/resume and bypass control
// ****************************************************
module ccsr_bank_ctl #(
   parameter STALL_SUPPORT = 1,
   parameter SECURE_BANK = 1,
   parameter WALLOC_SUPPORT = 1,
   parameter RALLOC_SUPPORT = 1,
   parameter SHARE_SUPPORT = 1,
   parameter TRANS_SUPPORT = 1
) (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // fault pipeline
   input wire stall_evt,
   input wire stall_sec,
   // resume commands to pipeline
   output wire retry,
   output wire term,
   output wire retry_sec,
   output reg retry_stage1,
   output wire stalled,
   // bank controls
   output reg xlate_en,
   output reg fault_interrupt_enable,
   output reg fault_report_enable,
   output reg fault_model_select,
   output reg user_cache_maint_enable,
   output reg private_asid_namespace,
   // bypass attributes
   output reg [1:0] bypass_security_attr,
   output reg [1:0] bypass_write_alloc_hint,
   output reg [1:0] bypass_read_alloc_hint,
   output reg [1:0] bypass_share_attr,
   output reg bypass_memtype_select,
   output reg [3:0] bypass_memory_attrs,
   output reg [1:0] bypass_transient_hint
);
   // ****************************************************
   // storage
   // ****************************************************
   reg [31:0] sctl;
   reg [31:0] attr;
   reg [31:0] attr2;
   reg [31:0] next_sctl;
   reg [31:0] next_rdata;
   reg addr_ok;
   reg wr_ok;
   wire acc_wr;
   wire setup;
   wire wr_sctl;
   wire wr_resume;
   wire wr_attr;
   wire wr_attr2;
   wire wide;

   ccsr_apb_port u_port (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .pready(pready),
      .pslverr(pslverr),
      .addr_ok(addr_ok),
      .wr_ok(wr_ok),
      .acc_wr(acc_wr),
      .setup(setup)
   );

   ccsr_resume_ctl #(
      .STALL_SUPPORT(STALL_SUPPORT)
   ) u_resume (
      .pclk(pclk),
      .presetn(presetn),
      .stall_evt(stall_evt),
      .stall_sec(stall_sec),
      .model_stall(sctl[`CCSR_B_FMODEL]),
      .resume_wr(wr_resume),
      .resume_tnr(pwdata[`CCSR_B_TNR]),
      .attr_wr(wr_attr | wr_attr2),
      .stalled(stalled),
      .retry(retry),
      .term(term),
      .retry_sec(retry_sec)
   );

   // ****************************************************
   // address decode
   // ****************************************************
   assign wr_sctl = acc_wr & (paddr == `CCSR_OFF_SCTL);
   // only bit 0 has meaning, upper bits dropped
   assign wr_resume = acc_wr & (paddr == `CCSR_OFF_RESUME);
   assign wr_attr = acc_wr & (paddr == `CCSR_OFF_ATTR);
   assign wr_attr2 = acc_wr & (paddr == `CCSR_OFF_ATTR2);
   assign wide = attr2[`CCSR_B_WIDE];

   always @* begin
      addr_ok = 1'b1;
      wr_ok = 1'b1;
      next_rdata = 32'h0000_0000;
      if (paddr == `CCSR_OFF_SCTL) begin
         next_rdata = sctl;
      end else if (paddr == `CCSR_OFF_RESUME) begin
         // write-only: reads return zero
         next_rdata = 32'h0000_0000;
      end else if (paddr == `CCSR_OFF_STATUS) begin
         wr_ok = 1'b0;
         next_rdata = {31'h0000_0000, stalled};
      end else if (paddr == `CCSR_OFF_ATTR) begin
         next_rdata = attr;
      end else if (paddr == `CCSR_OFF_ATTR2) begin
         next_rdata = attr2;
      end else begin
         addr_ok = 1'b0;
      end
   end

   // ****************************************************
   // control register write masking
   // ****************************************************
   always @* begin
      next_sctl = 32'h0000_0000;
      next_sctl[`CCSR_B_XLATE] = pwdata[`CCSR_B_XLATE];
      next_sctl[`CCSR_B_FRPT] = pwdata[`CCSR_B_FRPT];
      next_sctl[`CCSR_B_FIRQ] = pwdata[`CCSR_B_FIRQ];
      next_sctl[`CCSR_B_FMODEL] = pwdata[`CCSR_B_FMODEL];
      next_sctl[`CCSR_B_ASIDP] = pwdata[`CCSR_B_ASIDP];
      next_sctl[`CCSR_B_MTSEL] = pwdata[`CCSR_B_MTSEL];
      next_sctl[`CCSR_F_BYPASS_MEMORY_ATTRS] = pwdata[`CCSR_F_BYPASS_MEMORY_ATTRS];
      next_sctl[`CCSR_B_UCI] = pwdata[`CCSR_B_UCI];
      if (SECURE_BANK != 0) begin
         next_sctl[`CCSR_F_SEC] = pwdata[`CCSR_F_SEC];
      end
      if (WALLOC_SUPPORT != 0) begin
         next_sctl[`CCSR_F_WALLOC] = pwdata[`CCSR_F_WALLOC];
      end
      if (RALLOC_SUPPORT != 0) begin
         next_sctl[`CCSR_F_RALLOC] = pwdata[`CCSR_F_RALLOC];
      end
      if (SHARE_SUPPORT != 0) begin
         next_sctl[`CCSR_F_SHARE] = pwdata[`CCSR_F_SHARE];
      end
      if (TRANS_SUPPORT != 0) begin
         next_sctl[`CCSR_F_TRANS] = pwdata[`CCSR_F_TRANS];
      end
   end

   // ****************************************************
   // registers
   // ****************************************************
   // unknown-reset fields settle to zero here
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sctl <= `CCSR_SCTL_RST;
         attr <= 32'h0000_0000;
         attr2 <= 32'h0000_0000;
         prdata <= 32'h0000_0000;
      end else begin
         if (wr_sctl) begin
            sctl <= next_sctl;
         end
         if (wr_attr) begin
            attr <= pwdata;
         end
         if (wr_attr2) begin
            attr2 <= pwdata;
         end
         // read data captured in setup, held for access
         if (setup & ~pwrite) begin
            prdata <= next_rdata;
         end
      end
   end

   // ****************************************************
   // bank outputs
   // ****************************************************
   // a one-cycle lag after the write; traffic from
   // one cycle after the apb completion sees the new value
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xlate_en <= 1'b0;
         fault_interrupt_enable <= 1'b0;
         fault_report_enable <= 1'b0;
         fault_model_select <= 1'b0;
         user_cache_maint_enable <= 1'b0;
         private_asid_namespace <= 1'b0;
         bypass_security_attr <= 2'h0;
         bypass_write_alloc_hint <= 2'h0;
         bypass_read_alloc_hint <= 2'h0;
         bypass_share_attr <= 2'h0;
         bypass_memtype_select <= 1'b0;
         bypass_memory_attrs <= 4'h0;
         bypass_transient_hint <= 2'h0;
         retry_stage1 <= 1'b0;
      end else begin
         xlate_en <= sctl[`CCSR_B_XLATE];
         fault_interrupt_enable <= sctl[`CCSR_B_FIRQ];
         fault_report_enable <= sctl[`CCSR_B_FRPT];
         fault_model_select <= sctl[`CCSR_B_FMODEL];
         // ignored unless the wide address scheme is on
         user_cache_maint_enable <= sctl[`CCSR_B_UCI] & wide;
         private_asid_namespace <= sctl[`CCSR_B_ASIDP];
         // retries always go back to stage 1 so
         // translation control changes are seen
         retry_stage1 <= 1'b1;
         if (sctl[`CCSR_B_XLATE]) begin
            bypass_security_attr <= 2'h0;
            bypass_write_alloc_hint <= 2'h0;
            bypass_read_alloc_hint <= 2'h0;
            bypass_share_attr <= 2'h0;
            bypass_memtype_select <= 1'b0;
            bypass_memory_attrs <= 4'h0;
            bypass_transient_hint <= 2'h0;
         end else begin
            bypass_security_attr <= sctl[`CCSR_F_SEC];
            bypass_write_alloc_hint <= sctl[`CCSR_F_WALLOC];
            bypass_read_alloc_hint <= sctl[`CCSR_F_RALLOC];
            bypass_share_attr <= sctl[`CCSR_F_SHARE];
            bypass_memtype_select <= sctl[`CCSR_B_MTSEL];
            if (sctl[`CCSR_B_MTSEL]) begin
               bypass_memory_attrs <= sctl[`CCSR_F_BYPASS_MEMORY_ATTRS];
            end else begin
               bypass_memory_attrs <= 4'h0;
            end
            bypass_transient_hint <= sctl[`CCSR_F_TRANS];
         end
      end
   end
endmodule
`default_nettype wire

// >>> src/ccsr_defs.vh
// Function
// - resume write: 0 retries, 1 terminates stall
// - ignore resume when no stall support/stall
// - resume write clears stall status flag
// - retry restarts at stage 1 translation
// - resumed transaction keeps original security state
// - model switch to terminate keeps stall flag
// - attribute register writes also retry, clear
// - resume register 32-bit write-only, bit0 only
// - control fields reset unknown except 6:5
// - user cache maintenance only when wide address
// - bypass security select when translation off
// - security field only in secure banks
// - write allocate hint, RAZ/WI if unsupported
// - read allocate hint, RAZ/WI if unsupported
// - shareability override, RAZ/WI if unsupported
// - memtype select applies bypass memory attrs
// - optional transient hint, RAZ/WI when absent
// - private ASID namespace bit is hint
// - translation enable bit, bypass when zero
// - interrupt and report enables reset zero
`ifndef CCSR_DEFS_VH
`define CCSR_DEFS_VH
// ****************************************************
// register byte offsets
// ****************************************************
`define CCSR_OFF_SCTL 12'h000
`define CCSR_OFF_RESUME 12'h004
`define CCSR_OFF_STATUS 12'h008
`define CCSR_OFF_ATTR 12'h00C
`define CCSR_OFF_ATTR2 12'h010
// ****************************************************
// control, resume and attr2 register fields
// ****************************************************
`define CCSR_B_XLATE 0
`define CCSR_B_FRPT 5
`define CCSR_B_FIRQ 6
`define CCSR_B_FMODEL 7
`define CCSR_B_ASIDP 12
`define CCSR_F_TRANS 15:14
`define CCSR_F_BYPASS_MEMORY_ATTRS 19:16
`define CCSR_B_MTSEL 20
`define CCSR_F_SHARE 23:22
`define CCSR_F_RALLOC 25:24
`define CCSR_F_WALLOC 27:26
`define CCSR_F_SEC 29:28
`define CCSR_B_UCI 30
`define CCSR_B_TNR 0
`define CCSR_B_WIDE 0
`define CCSR_SCTL_RST 32'h0000_0000
`define CCSR_SEC_SECURE 2'h2
`define CCSR_SEC_NONSEC 2'h3
// ****************************************************
// resume state machine
// ****************************************************
`define CCSR_ST_RUN 1'b0
`define CCSR_ST_STALL 1'b1
`endif

// >>> src/ccsr_apb_port.v
`timescale 1ns/1ps
`default_nettype none
// ****************************************************
// apb handshake: one wait-free access phase
// ****************************************************
module ccsr_apb_port (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // apb
   input wire psel,
   input wire penable,
   input wire pwrite,
   output reg pready,
   output reg pslverr,
   // decode from register file
   input wire addr_ok,
   input wire wr_ok,
   // access strobes
   output wire acc_wr,
   output wire setup
);
   assign setup = psel & ~penable;
   // write lands only at the completing edge
   assign acc_wr = psel & penable & pready & pwrite & ~pslverr;
   // registered answer so pready comes from a flop
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (setup) begin
         pready <= 1'b1;
         pslverr <= ~addr_ok | (pwrite & ~wr_ok);
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// >>> src/ccsr_resume_ctl.v
`timescale 1ns/1ps
`default_nettype none
`include "ccsr_defs.vh"
// ****************************************************
// stall hold and resume sequencing
// ****************************************************
module ccsr_resume_ctl #(
   parameter STALL_SUPPORT = 1
) (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // fault side
   input wire stall_evt,
   input wire stall_sec,
   input wire model_stall,
   // software side
   input wire resume_wr,
   input wire resume_tnr,
   input wire attr_wr,
   // results
   output reg stalled,
   output reg retry,
   output reg term,
   output reg retry_sec
);
   reg held_sec;
   wire go;
   wire take;
   // attribute writes retry as well
   assign go = stalled & (resume_wr | attr_wr);
   // model switch does not touch stall flag
   assign take = (STALL_SUPPORT != 0) & stall_evt & model_stall;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stalled <= `CCSR_ST_RUN;
         retry <= 1'b0;
         term <= 1'b0;
         retry_sec <= 1'b0;
         held_sec <= 1'b0;
      end else begin
         retry <= go & ~(resume_wr & resume_tnr);
         term <= go & resume_wr & resume_tnr;
         retry_sec <= go ? held_sec : retry_sec;
         case (stalled)
            `CCSR_ST_RUN: begin
               if (take) begin
                  stalled <= `CCSR_ST_STALL;
                  held_sec <= stall_sec;
               end
            end
            default: begin
               // new stall in the clearing cycle wins
               if (go & take) begin
                  held_sec <= stall_sec;
               end else if (go) begin
                  stalled <= `CCSR_ST_RUN;
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> bench/ccsr_bank_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// stall, resume and bypass checks
// ********
module ccsr_bank_chk (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   // stall and bypass
   input wire logic stall_evt,
   input wire logic retry,
   input wire logic term,
   input wire logic retry_stage1,
   input wire logic stalled,
   input wire logic xlate_en,
   input wire logic [1:0] bypass_security_attr,
   input wire logic [1:0] bypass_share_attr,
   input wire logic bypass_memtype_select,
   input wire logic [3:0] bypass_memory_attrs
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic acc = psel && penable && pready;
   wire logic wr_res = acc && pwrite && paddr == 12'h004;
   wire logic wr_att = acc && pwrite && paddr inside {12'h00c, 12'h010};
   // a stall event in the clearing cycle wins, so leave it out
   sequence s_resume(terminate_not_retry);
      wr_res && stalled && !stall_evt && pwdata[0] == terminate_not_retry;
   endsequence
   sequence s_release;
      (wr_res || wr_att) && stalled && !stall_evt;
   endsequence
   property p_retry;
      s_resume(1'b0) |=> retry && !term;
   endproperty
   a_retry: assert property (p_retry)
      else $error("resume with retry gave no retry");
   property p_term;
      s_resume(1'b1) |=> term && !retry;
   endproperty
   a_term: assert property (p_term)
      else $error("resume with terminate gave no term");
   property p_clear;
      s_release |=> !stalled;
   endproperty
   a_clear: assert property (p_clear)
      else $error("stall flag not cleared");
   property p_ignore;
      wr_res && !stalled |=> !retry && !term;
   endproperty
   a_ignore: assert property (p_ignore)
      else $error("resume acted without a stall");
   property p_attr;
      wr_att && stalled && !stall_evt |=> retry && !term;
   endproperty
   a_attr: assert property (p_attr)
      else $error("attribute write did not retry");
   property p_hold;
      stalled && !wr_res && !wr_att |=> stalled;
   endproperty
   a_hold: assert property (p_hold)
      else $error("stall flag dropped on its own");
   property p_once;
      retry || term |-> !(retry && term) ##1 !retry && !term;
   endproperty
   a_once: assert property (p_once)
      else $error("resume acted more than once");
   property p_stage1;
      retry |-> retry_stage1;
   endproperty
   a_stage1: assert property (p_stage1)
      else $error("retry not from stage one");
   property p_bypass;
      xlate_en |-> bypass_security_attr == 2'h0 &&
         bypass_share_attr == 2'h0 && !bypass_memtype_select;
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("bypass attributes while translating");
   property p_bypass_memory_attrs;
      !bypass_memtype_select |-> bypass_memory_attrs == 4'h0;
   endproperty
   a_bypass_memory_attrs: assert property (p_bypass_memory_attrs)
      else $error("memory attributes without memtype select");
   property p_rdres;
      acc && !pwrite && paddr == 12'h004 |-> prdata == 32'h0000_0000;
   endproperty
   a_rdres: assert property (p_rdres)
      else $error("resume register read not zero");
endmodule
bind ccsr_bank_ctl ccsr_bank_chk ccsr_bank_chk_i (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .stall_evt, .retry, .term, .retry_stage1,
   .stalled, .xlate_en, .bypass_security_attr, .bypass_share_attr,
   .bypass_memtype_select, .bypass_memory_attrs
);
`default_nettype wire

// >>> bench/ccsr_bank_ctl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccsr_defs.vh"
module ccsr_bank_ctl_tb;
   // ********
   // pins and counters
   // ********
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic stall_evt = 1'b0;
   logic stall_sec = 1'b0;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, retry, term, retry_sec, retry_stage1;
   wire logic stalled, xlate_en, fault_interrupt_enable;
   wire logic fault_report_enable, fault_model_select;
   wire logic user_cache_maint_enable, private_asid_namespace;
   wire logic [1:0] bypass_security_attr, bypass_write_alloc_hint;
   wire logic [1:0] bypass_read_alloc_hint, bypass_share_attr;
   wire logic bypass_memtype_select;
   wire logic [3:0] bypass_memory_attrs;
   wire logic [1:0] bypass_transient_hint;
   wire logic [14:0] byp_seen = {bypass_security_attr,
      bypass_write_alloc_hint, bypass_read_alloc_hint, bypass_share_attr,
      bypass_memtype_select, bypass_memory_attrs, bypass_transient_hint};
   localparam logic [31:0] MASK = 32'h7fdf_d0e1;
   int miscompares = 0;
   int n_compared = 0;
   int seed = 32'h68cc_825b;
   logic [31:0] rd, c;
   logic err, s;
   ccsr_bank_ctl ccsr_bank_ctl_i (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .stall_evt,
      .stall_sec, .retry, .term, .retry_sec, .retry_stage1, .stalled,
      .xlate_en, .fault_interrupt_enable, .fault_report_enable,
      .fault_model_select, .user_cache_maint_enable,
      .private_asid_namespace, .bypass_security_attr,
      .bypass_write_alloc_hint, .bypass_read_alloc_hint,
      .bypass_share_attr, .bypass_memtype_select, .bypass_memory_attrs,
      .bypass_transient_hint);
   always #2.5 pclk = ~pclk;
   // ********
   // helpers
   // ********
   task results;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] got, input logic [31:0] e);
      n_compared++;
      if (got !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, e, got);
      end
   endtask
   // bounded wait: a hung slave ends the run
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 16) begin
         miscompares++;
         results;
      end
      @(posedge pclk);
   endtask
   task stall_inj(input logic sec);
      stall_evt <= 1'b1;
      stall_sec <= sec;
      @(posedge pclk);
      stall_evt <= 1'b0;
      @(posedge pclk);
   endtask
   function logic [14:0] byp(input logic [31:0] v);
      if (v[0])
         return 15'h0000;
      return {v[29:22], v[20], v[20] ? v[19:16] : 4'h0, v[15:14]};
   endfunction
   // ********
   // main sequence
   // ********
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, `CCSR_OFF_SCTL, 32'h0000_0000);
      chk("sctl_rst", rd, 32'h0000_0000);
      chk("stage1", retry_stage1, 32'h0000_0001);
      chk("rst_en", {fault_interrupt_enable,
         fault_report_enable}, 32'h0000_0000);
      for (int i = 0; i < 16; i++) begin
         c = $random(seed);
         if (i == 0) c = 32'hffff_ffff;
         if (i == 1) c = 32'hffef_ffff;
         if (i % 2 == 1) c[0] = 1'b0;
         apb(1'b1, `CCSR_OFF_SCTL, c);
         @(posedge pclk);
         chk("bypass", byp_seen, byp(c));
         chk("ctl", {xlate_en, private_asid_namespace},
            {c[0], c[12]});
         chk("en", {fault_interrupt_enable, fault_report_enable,
            fault_model_select}, {c[6], c[5], c[7]});
         apb(1'b0, `CCSR_OFF_SCTL, 32'h0000_0000);
         chk("sctl", rd, c & MASK);
      end
      apb(1'b0, `CCSR_OFF_RESUME, 32'h0000_0000);
      chk("res_rd", rd, 32'h0000_0000);
      apb(1'b1, `CCSR_OFF_STATUS, 32'h0000_0001);
      chk("st_wr", err, 32'h0000_0001);
      apb(1'b0, 12'h7fc, 32'h0000_0000);
      chk("unmapped", err, 32'h0000_0001);
      // user cache maintenance follows the wide address select
      apb(1'b1, `CCSR_OFF_SCTL, 32'h4000_0080);
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, `CCSR_OFF_ATTR2, i);
         @(posedge pclk);
         chk("uci", user_cache_maint_enable, i);
      end
      for (int i = 0; i < 6; i++) begin
         c = $random(seed);
         s = c[1];
         apb(1'b1, `CCSR_OFF_RESUME, c);
         chk("idle_res", {retry, term, stalled}, 32'h0000_0000);
         stall_inj(s);
         apb(1'b0, `CCSR_OFF_STATUS, 32'h0000_0000);
         chk("st_rd", rd[0], 32'h0000_0001);
         if (i == 5)
            apb(1'b1, `CCSR_OFF_ATTR, c);
         else
            apb(1'b1, `CCSR_OFF_RESUME, c);
         if (i == 5)
            c[0] = 1'b0;
         chk("resume", {retry, term, stalled, retry_sec},
            {~c[0], c[0], 1'b0, s});
         @(posedge pclk);
         chk("once", {retry, term}, 32'h0000_0000);
      end
      // switch to the terminate model while stalled
      stall_inj(1'b1);
      apb(1'b1, `CCSR_OFF_SCTL, 32'h0000_0000);
      repeat (4) @(posedge pclk);
      chk("keep", stalled, 32'h0000_0001);
      apb(1'b1, `CCSR_OFF_RESUME, 32'h0000_0001);
      chk("term", {term, stalled}, 32'h0000_0002);
      stall_inj(1'b1);
      chk("no_stall", stalled, 32'h0000_0000);
      // reset in mid stall
      apb(1'b1, `CCSR_OFF_SCTL, 32'h0000_00e0);
      stall_inj(1'b0);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("rst_stl", stalled, 32'h0000_0000);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, `CCSR_OFF_SCTL, 32'h0000_0000);
      chk("rst_ctl", rd, 32'h0000_0000);
      chk("rst_en2", {fault_interrupt_enable, fault_report_enable,
         fault_model_select}, 32'h0000_0000);
      results;
   end
endmodule
`default_nettype wire
